// ---- core/gss_pkg.sv ----
// constants, types and register map of the gate setup sequencer
package gss_pkg;
   // bus clock
   localparam int unsigned CLK_MHZ        = 200;
   // documented times, in their own units
   localparam int unsigned HOLD_MAX_MIN   = 30;
   localparam int unsigned PAR_HOLD_S     = 4;
   localparam int unsigned DIR_HOLD_S     = 9;
   localparam int unsigned ROLL_S         = 3;
   localparam int unsigned SAVE_HOLD_S    = 5;
   // one second tick is derived from the clock rate
   localparam int unsigned TICK_CYC       = CLK_MHZ * 1000000;
   localparam int unsigned MS_PER_S       = 1000;
   // battery thresholds in millivolts
   localparam logic [15:0] BAT_OPEN_MV    = 16'h5dc0; // 24000 mV
   localparam logic [15:0] BAT_CRIT_MV    = 16'h55f0; // 22000 mV
   // register byte offsets (word aligned)
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_MOTOR      = 8'h04;
   localparam logic [7:0]  REG_STATUS     = 8'h08;
   localparam logic [7:0]  REG_DISP       = 8'h0c;
   localparam logic [7:0]  REG_BAT        = 8'h10;
   // control register fields
   localparam int unsigned CTRL_DLY_LSB   = 0;
   localparam int unsigned CTRL_DLY_W     = 5;
   localparam int unsigned CTRL_MSEL_BIT  = 8;
   localparam logic [4:0]  DLY_RST        = 5'h00;
   localparam logic [3:0]  MOTOR_RST      = 4'h0;
   localparam logic [7:0]  SEC_PER_MIN    = 8'h3c;
   // display codes
   typedef enum logic [3:0] {
      GSS_D_STOP, GSS_D_PAR, GSS_D_DIR_ON, GSS_D_DIR_FL, GSS_D_ROLL_UP, GSS_D_ROLL_DN,
      GSS_D_ALL_FL, GSS_D_UP_ON, GSS_D_UP_FL, GSS_D_MID
   } gss_disp_t;
   typedef enum {GSS_STOP, GSS_DIR, GSS_UPPER, GSS_MIDDLE} gss_state_t;
endpackage : gss_pkg

// ---- core/gss_hold_timer.sv ----
// counts seconds while a level is held; restarts on release
`timescale 1ns/1ps
module gss_hold_timer
   import gss_pkg::*;
#(
   parameter int unsigned W = 8
) (
   input  wire logic         mclk,
   input  wire logic         rstn,
   input  wire logic         tick,
   input  wire logic         held,
   output logic [W-1:0]      secs
);
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         secs <= '0;
      end else if (!held) begin
         secs <= '0;
      end else if (tick && secs != {W{1'b1}}) begin
         secs <= secs + W'(1);
      end
   end
endmodule : gss_hold_timer

// ---- core/gss_gate_setup_sequencer.sv ----
// gate setup sequencer: power-fail closing, safety inputs, setup steps, AHB-Lite registers
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module gss_gate_setup_sequencer
   import gss_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC,
   parameter int unsigned POS_W       = 16
) (
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic              mains_ok,
   input  wire logic [15:0]       bat_mv,
   input  wire logic              fire_alarm_input,
   input  wire logic              brake_ok,
   input  wire logic              knob_btn,
   input  wire logic              key_open,
   input  wire logic              key_close,
   input  wire logic              key_stop,
   input  wire logic              key_unlock,
   input  wire logic [POS_W-1:0]  enc_pos,
   input  wire logic [3:0]        inv_motor,
   output logic                   motor_open_ff,
   output logic                   motor_close_ff,
   output logic                   range_bypass_ff,
   output logic                   inv_mismatch_ff,
   output logic [3:0]             disp_code_ff,
   output logic                   disp_blank_ff
);
   localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
   localparam logic [7:0] PAR_S8  = 8'(PAR_HOLD_S);
   localparam logic [7:0] DIR_S8  = 8'(DIR_HOLD_S);
   localparam logic [7:0] ROLL_S8 = 8'(ROLL_S);
   localparam logic [7:0] SAVE_S8 = 8'(SAVE_HOLD_S);

   logic [TW-1:0]      div_ff;
   logic               tick_ff;
   logic [7:0]         knob_s, stop_s, jog_s;
   logic [4:0]         dly_ff;
   logic [3:0]         motor_ff;
   logic               dir_set_ff, up_set_ff, mid_set_ff, dir_rev_ff;
   logic [POS_W-1:0]   up_pos_ff, mid_pos_ff;
   gss_state_t         state_ff;
   logic               knob_d_ff, stop_d_ff, jogged_ff, saved_ff;
   logic               jog_seen_ff;
   logic [15:0]        fail_s_ff;
   logic               pf_close, crit_close, force_close;
   logic               jog_ok, jog_up, jog_dn, save_now, knob_short;
   logic               blink_ff;
   logic               ap_ff, ap_wr_ff;
   logic [7:0]         ap_addr_ff;

   // one-second enable pulse; everything slow runs from it
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         div_ff  <= '0;
         tick_ff <= 1'b0;
      end else if (div_ff == TW'(TICK_CYCLES - 1)) begin
         div_ff  <= '0;
         tick_ff <= 1'b1;
      end else begin
         div_ff  <= div_ff + TW'(1);
         tick_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         blink_ff <= 1'b0;
      end else if (tick_ff) begin
         blink_ff <= ~blink_ff;
      end
   end

   gss_hold_timer #(.W(8)) u_knob (.mclk(mclk), .rstn(rstn), .tick(tick_ff), .held(knob_btn), .secs(knob_s));
   gss_hold_timer #(.W(8)) u_stop (.mclk(mclk), .rstn(rstn), .tick(tick_ff), .held(key_stop), .secs(stop_s));
   gss_hold_timer #(.W(8)) u_jog  (.mclk(mclk), .rstn(rstn), .tick(tick_ff), .held(jog_up | jog_dn), .secs(jog_s));

   // power-fail timing: seconds since mains went away
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         fail_s_ff <= '0;
      end else if (mains_ok) begin
         fail_s_ff <= '0;
      end else if (tick_ff && fail_s_ff != 16'hffff) begin
         fail_s_ff <= fail_s_ff + 16'h0001;
      end
   end

   // delay is compared in seconds so zero minutes closes at once
   assign pf_close    = !mains_ok && (fail_s_ff >= 16'(dly_ff) * 16'(SEC_PER_MIN)
                        || bat_mv < BAT_OPEN_MV);
   assign crit_close  = bat_mv < BAT_CRIT_MV;
   assign force_close = pf_close || crit_close || !fire_alarm_input;

   assign jog_ok     = key_unlock && state_ff != GSS_STOP;
   assign jog_up     = jog_ok && key_open && !key_close;
   assign jog_dn     = jog_ok && key_close && !key_open;
   // save fires once when the stop hold reaches five seconds
   assign save_now   = key_stop && stop_s == SAVE_S8 && !saved_ff;
   assign knob_short = knob_d_ff && !knob_btn && state_ff != GSS_STOP;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         knob_d_ff <= 1'b0;
         stop_d_ff <= 1'b0;
         saved_ff  <= 1'b0;
      end else begin
         knob_d_ff <= knob_btn;
         stop_d_ff <= key_stop;
         saved_ff  <= key_stop && (saved_ff || save_now);
      end
   end

   // setup steps
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= GSS_STOP;
      end else begin
         case (state_ff)
            GSS_STOP: begin
               if (knob_btn && knob_s == DIR_S8 && !force_close) begin
                  state_ff <= GSS_DIR;
               end
            end
            GSS_DIR: begin
               if (save_now || knob_short) begin
                  state_ff <= GSS_UPPER;
               end
            end
            GSS_UPPER: begin
               if (save_now || knob_short) begin
                  state_ff <= GSS_MIDDLE;
               end
            end
            GSS_MIDDLE: begin
               if (save_now || knob_short) begin
                  state_ff <= GSS_STOP;
               end
            end
            default: state_ff <= GSS_STOP;
         endcase
      end
   end

   // stored setup values; a skip leaves them untouched
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dir_set_ff <= 1'b0;
         dir_rev_ff <= 1'b0;
         up_set_ff  <= 1'b0;
         mid_set_ff <= 1'b0;
         up_pos_ff  <= '0;
         mid_pos_ff <= '0;
      end else if (save_now) begin
         if (state_ff == GSS_DIR) begin
            dir_set_ff <= 1'b1;
            dir_rev_ff <= jogged_ff;
         end
         if (state_ff == GSS_UPPER) begin
            up_set_ff <= 1'b1;
            up_pos_ff <= enc_pos;
         end
         if (state_ff == GSS_MIDDLE) begin
            mid_set_ff <= 1'b1;
            mid_pos_ff <= enc_pos;
         end
      end
   end

   // remembers the last jog direction in the direction step
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         jogged_ff <= 1'b0;
      end else if (state_ff == GSS_DIR && jog_dn) begin
         jogged_ff <= 1'b1;
      end else if (state_ff == GSS_DIR && jog_up) begin
         jogged_ff <= 1'b0;
      end
   end

   // any jog in the direction step, either way; the segments then flash until the step is left
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         jog_seen_ff <= 1'b0;
      end else if (state_ff != GSS_DIR) begin
         jog_seen_ff <= 1'b0;
      end else if (jog_up || jog_dn) begin
         jog_seen_ff <= 1'b1;
      end
   end

   // motor drive: forced closing wins over jogging, brake vetoes closing
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         motor_open_ff   <= 1'b0;
         motor_close_ff  <= 1'b0;
         range_bypass_ff <= 1'b0;
      end else begin
         motor_close_ff  <= brake_ok && (force_close || jog_dn);
         motor_open_ff   <= !force_close && jog_up;
         range_bypass_ff <= state_ff == GSS_DIR && (jog_up || jog_dn);
      end
   end

   // inverter parameter set must match the selected motor
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         inv_mismatch_ff <= 1'b0;
      end else begin
         inv_mismatch_ff <= inv_motor != motor_ff;
      end
   end

   // display
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         disp_code_ff  <= 4'(GSS_D_STOP);
         disp_blank_ff <= 1'b0;
      end else begin
         disp_blank_ff <= 1'b0;
         case (state_ff)
            GSS_STOP: begin
               disp_code_ff <= (knob_btn && knob_s >= PAR_S8) ? 4'(GSS_D_PAR) : 4'(GSS_D_STOP);
            end
            GSS_DIR: begin
               if ((jog_up || jog_dn) && jog_s >= ROLL_S8) begin
                  disp_code_ff <= jog_up ? 4'(GSS_D_ROLL_UP) : 4'(GSS_D_ROLL_DN);
               end else if (jog_seen_ff || stop_d_ff) begin
                  disp_code_ff  <= 4'(GSS_D_ALL_FL);
                  disp_blank_ff <= blink_ff;
               end else begin
                  disp_code_ff  <= dir_set_ff ? 4'(GSS_D_DIR_ON) : 4'(GSS_D_DIR_FL);
                  disp_blank_ff <= !dir_set_ff && blink_ff;
               end
            end
            GSS_UPPER: begin
               disp_code_ff  <= up_set_ff ? 4'(GSS_D_UP_ON) : 4'(GSS_D_UP_FL);
               disp_blank_ff <= !up_set_ff && blink_ff;
            end
            GSS_MIDDLE: begin
               disp_code_ff  <= 4'(GSS_D_MID);
               disp_blank_ff <= !mid_set_ff && blink_ff;
            end
            default: disp_code_ff <= 4'(GSS_D_STOP);
         endcase
      end
   end

   // AHB-Lite slave, zero wait states
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ap_ff      <= 1'b0;
         ap_wr_ff   <= 1'b0;
         ap_addr_ff <= '0;
      end else if (hready) begin
         ap_ff      <= hsel && htrans[1];
         ap_wr_ff   <= hwrite;
         ap_addr_ff <= haddr[7:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dly_ff   <= DLY_RST;
         motor_ff <= MOTOR_RST;
      end else if (ap_ff && ap_wr_ff && ap_addr_ff == REG_CTRL) begin
         dly_ff <= (hwdata[CTRL_DLY_LSB +: CTRL_DLY_W] > 5'(HOLD_MAX_MIN))
                   ? 5'(HOLD_MAX_MIN) : hwdata[CTRL_DLY_LSB +: CTRL_DLY_W];
      end else if (ap_ff && ap_wr_ff && ap_addr_ff == REG_MOTOR) begin
         motor_ff <= hwdata[3:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hrdata <= '0;
         if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
               REG_CTRL:   hrdata <= {27'h0, dly_ff};
               REG_MOTOR:  hrdata <= {28'h0, motor_ff};
               REG_STATUS: hrdata <= {19'h0, dir_rev_ff, 2'(state_ff), mid_set_ff, up_set_ff, dir_set_ff,
                                      inv_mismatch_ff, crit_close, pf_close, !fire_alarm_input,
                                      !brake_ok, motor_close_ff, motor_open_ff};
               REG_DISP:   hrdata <= {{(32-POS_W){1'b0}}, up_pos_ff};
               REG_BAT:    hrdata <= {16'h0, bat_mv};
               default:    hrdata <= '0;
            endcase
         end
      end
   end

   AST_CRIT_CLOSE: assert property (@(posedge mclk) disable iff (!rstn)
      (bat_mv < BAT_CRIT_MV && brake_ok) |=> motor_close_ff)
      else $error("critical battery did not close");
   AST_BRAKE: assert property (@(posedge mclk) disable iff (!rstn)
      !brake_ok |=> !motor_close_ff)
      else $error("closing while brake open");
   AST_FIRE: assert property (@(posedge mclk) disable iff (!rstn)
      (!fire_alarm_input && brake_ok) |=> motor_close_ff && !motor_open_ff)
      else $error("alarm did not close");
   AST_PF24: assert property (@(posedge mclk) disable iff (!rstn)
      (!mains_ok && bat_mv < BAT_OPEN_MV && brake_ok) |=> motor_close_ff)
      else $error("low battery without mains did not close");
   sequence s_in_stop; state_ff == GSS_STOP; endsequence
   AST_ENTRY: assert property (@(posedge mclk) disable iff (!rstn)
      (state_ff == GSS_DIR && $past(state_ff) != GSS_DIR) |-> $past(state_ff == GSS_STOP))
      else $error("direction entered from wrong state");
   AST_LOCK: assert property (@(posedge mclk) disable iff (!rstn)
      (!key_unlock && mains_ok && !force_close) |=> !motor_open_ff)
      else $error("jog while locked");
   AST_SAVE_ADV: assert property (@(posedge mclk) disable iff (!rstn)
      (save_now && state_ff == GSS_UPPER) |=> state_ff == GSS_MIDDLE && up_set_ff)
      else $error("upper save did not advance");
   AST_NOSAVE_EARLY: assert property (@(posedge mclk) disable iff (!rstn)
      (state_ff == GSS_DIR && !dir_set_ff && stop_s < SAVE_S8 && !knob_short) |=> !dir_set_ff)
      else $error("saved before hold ended");
   AST_STOP_ONLY: assert property (@(posedge mclk) disable iff (!rstn)
      s_in_stop ##1 state_ff != GSS_STOP |-> $past(knob_s) == DIR_S8)
      else $error("left stop without nine-second hold");
endmodule : gss_gate_setup_sequencer

// ---- testbench/gss_drive_model.sv ----
// drive model: inverter reporting the fitted motor and an encoder that follows the motor commands
`timescale 1ns/1ps
module gss_drive_model #(
   parameter int unsigned POS_W = 16
) (
   input  wire logic             mclk,
   input  wire logic             rstn,
   input  wire logic             motor_open_ff,
   input  wire logic             motor_close_ff,
   input  wire logic [3:0]       fitted_motor,
   output logic      [POS_W-1:0] enc_pos,
   output logic      [3:0]       inv_motor
);
   // the fitted motor type is a site setting, so the inverter reports it as-is
   assign inv_motor = fitted_motor;
   // starts a quarter of the way into the counter range (16'h4000) so that jogging either way stays in range
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         enc_pos <= POS_W'(16'h4000);
      end else if (motor_open_ff && !motor_close_ff) begin
         enc_pos <= enc_pos + 1'b1;
      end else if (motor_close_ff && !motor_open_ff) begin
         enc_pos <= enc_pos - 1'b1;
      end
   end
endmodule : gss_drive_model

// ---- testbench/gss_gate_setup_sequencer_bench.sv ----
// self-checking bench of the gate setup sequencer
`timescale 1ns/1ps
module gss_gate_setup_sequencer_bench;
   import gss_pkg::*;
   localparam int unsigned TK = 10;
   logic        mclk, rstn, hsel, hwrite, mains_ok, fire_alarm_input, brake_ok, key_unlock;
   logic        knob_btn, key_open, key_close, key_stop, hreadyout, hresp, disp_blank_ff;
   logic        motor_open_ff, motor_close_ff, range_bypass_ff, inv_mismatch_ff;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] bat_mv, enc_pos;
   logic [3:0]  inv_motor, fitted_motor, disp_code_ff;
   logic [15:0] corner [4];
   logic        blank0;
   int          n_mismatch, num_checks, cyc;
   integer      seed;

   gss_gate_setup_sequencer #(.TICK_CYCLES(TK), .POS_W(16)) i_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mains_ok(mains_ok), .bat_mv(bat_mv),
      .fire_alarm_input(fire_alarm_input), .brake_ok(brake_ok), .knob_btn(knob_btn), .key_open(key_open),
      .key_close(key_close), .key_stop(key_stop), .key_unlock(key_unlock), .enc_pos(enc_pos),
      .inv_motor(inv_motor), .motor_open_ff(motor_open_ff), .motor_close_ff(motor_close_ff),
      .range_bypass_ff(range_bypass_ff), .inv_mismatch_ff(inv_mismatch_ff), .disp_code_ff(disp_code_ff),
      .disp_blank_ff(disp_blank_ff));
   gss_drive_model #(.POS_W(16)) i_drive (.mclk(mclk), .rstn(rstn), .motor_open_ff(motor_open_ff),
      .motor_close_ff(motor_close_ff), .fitted_motor(fitted_motor), .enc_pos(enc_pos), .inv_motor(inv_motor));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // a hang anywhere ends here; the tests need well under this many cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask : idle

   // one single AHB-Lite transfer; each phase is held until hready is seen high
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdat);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rdat = hrdata;
      chk(32'(hresp), 32'h0, "response");
   endtask : bus

   task automatic rdchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input string what);
      bus(1'b0, 32'(a), 32'h0, rd);
      chk(rd & mask, exp, what);
   endtask : rdchk

   task automatic wait_disp(input logic [3:0] code, input int lim, input string what);
      int i;
      i = 0;
      while (disp_code_ff !== code && i < lim) begin
         @(posedge mclk);
         i++;
      end
      chk(32'(disp_code_ff), 32'(code), what);
   endtask : wait_disp

   task automatic do_reset;
      rstn <= 1'b0;
      idle(2);
      rstn <= 1'b1;
   endtask : do_reset

   // closing demanded by the battery, with the hold delay not yet run out
   function automatic logic exp_close(input logic mains, input logic [15:0] mv);
      return (mv < BAT_CRIT_MV) || (!mains && mv < BAT_OPEN_MV);
   endfunction : exp_close

   initial begin
      seed = 32'h6aac50f5;
      corner = '{16'h55ef, 16'h55f0, 16'h5dbf, 16'h5dc0};
      {hsel, hwrite, knob_btn, key_open, key_close, key_stop, key_unlock} = 7'h00;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'b00;
      hsize = 3'b010;
      mains_ok = 1'b1;
      bat_mv = 16'h6590;
      fire_alarm_input = 1'b1;
      brake_ok = 1'b1;
      fitted_motor = 4'h3;
      rstn = 1'b0;
      idle(2);
      rstn <= 1'b1;
      rdchk(REG_CTRL, 32'hffffffff, 32'(DLY_RST), "delay reset");
      rdchk(REG_MOTOR, 32'hffffffff, 32'(MOTOR_RST), "motor reset");
      rdchk(8'h20, 32'hffffffff, 32'h0, "unmapped read");
      chk(32'(inv_mismatch_ff), 32'h1, "mismatch default");
      bus(1'b1, 32'(REG_MOTOR), 32'h3, rd);
      idle(2);
      chk(32'(inv_mismatch_ff), 32'h0, "mismatch cleared");
      bus(1'b1, 32'(REG_CTRL), 32'h1f, rd);
      rdchk(REG_CTRL, 32'h1f, 32'h1e, "delay clamp");
      $display("test registers done");
      fire_alarm_input <= 1'b0;
      idle(3);
      chk(32'(motor_close_ff), 32'h1, "alarm closes");
      brake_ok <= 1'b0;
      idle(3);
      chk(32'(motor_close_ff), 32'h0, "brake blocks");
      fire_alarm_input <= 1'b1;
      brake_ok <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         mains_ok <= 1'(i[0] ^ $random(seed));
         bat_mv <= (i < 4) ? corner[i] : 16'h5000 + 16'($random(seed) & 32'h1fff);
         idle(3);
         chk(32'(motor_close_ff), 32'(exp_close(mains_ok, bat_mv)), "battery close");
      end
      $display("test power done");
      mains_ok <= 1'b1;
      bat_mv <= 16'h6590;
      bus(1'b1, 32'(REG_CTRL), 32'h1, rd);
      mains_ok <= 1'b0;
      idle(500);
      chk(32'(motor_close_ff), 32'h0, "hold delay");
      idle(200);
      chk(32'(motor_close_ff), 32'h1, "delay ran out");
      mains_ok <= 1'b1;
      do_reset();
      $display("test hold delay done");
      knob_btn <= 1'b1;
      idle(2 * TK);
      chk(32'(disp_code_ff), 32'(GSS_D_STOP), "stop shown early");
      wait_disp(GSS_D_PAR, 4 * TK, "parameter shown");
      wait_disp(GSS_D_DIR_FL, 7 * TK, "direction flashing");
      rdchk(REG_STATUS, 32'hc00, 32'h400, "in direction step");
      key_close <= 1'b1;
      idle(2 * TK);
      chk(32'(motor_close_ff), 32'h0, "locked keyboard");
      key_unlock <= 1'b1;
      idle(4 * TK);
      chk(32'(disp_code_ff), 32'(GSS_D_ROLL_DN), "rolling down");
      chk(32'(range_bypass_ff), 32'h1, "range bypass");
      chk(32'(motor_close_ff), 32'h1, "jog close");
      key_close <= 1'b0;
      wait_disp(GSS_D_ALL_FL, 5, "all flashing");
      key_stop <= 1'b1;
      idle(2 * TK);
      key_stop <= 1'b0;
      idle(2);
      rdchk(REG_STATUS, 32'hc80, 32'h400, "short stop discarded");
      key_stop <= 1'b1;
      idle(6 * TK);
      key_stop <= 1'b0;
      rdchk(REG_STATUS, 32'h1c80, 32'h1880, "direction saved");
      chk(32'(disp_code_ff), 32'(GSS_D_UP_FL), "upper flashing");
      blank0 = disp_blank_ff;
      idle(TK);
      chk(32'(disp_blank_ff), 32'(!blank0), "upper blinks");
      key_open <= 1'b1;
      idle(20);
      key_open <= 1'b0;
      key_stop <= 1'b1;
      idle(6 * TK);
      key_stop <= 1'b0;
      rdchk(REG_STATUS, 32'hd00, 32'hd00, "upper saved");
      rdchk(REG_DISP, 32'hffff, 32'(enc_pos), "upper position");
      knob_btn <= 1'b0;
      idle(3);
      knob_btn <= 1'b1;
      wait_disp(GSS_D_DIR_ON, 10 * TK, "direction steady");
      knob_btn <= 1'b0;
      wait_disp(GSS_D_UP_ON, 5, "upper steady");
      chk(32'(disp_blank_ff), 32'h0, "upper not flashing");
      do_reset();
      $display("test setup save done");
      knob_btn <= 1'b1;
      wait_disp(GSS_D_DIR_FL, 10 * TK, "direction again");
      key_open <= 1'b1;
      idle(4 * TK);
      chk(32'(disp_code_ff), 32'(GSS_D_ROLL_UP), "rolling up");
      chk(32'(motor_open_ff), 32'h1, "jog open");
      key_open <= 1'b0;
      wait_disp(GSS_D_ALL_FL, 5, "all flashing after open");
      knob_btn <= 1'b0;
      idle(3);
      rdchk(REG_STATUS, 32'hc80, 32'h800, "direction skipped");
      rdchk(REG_DISP, 32'hffff, 32'h0, "upper before skip");
      knob_btn <= 1'b1;
      idle(2);
      knob_btn <= 1'b0;
      idle(3);
      rdchk(REG_STATUS, 32'hd00, 32'hc00, "upper skipped");
      rdchk(REG_DISP, 32'hffff, 32'h0, "upper unchanged");
      $display("test skips done");
      tally_and_finish();
   end
endmodule : gss_gate_setup_sequencer_bench
